// file: hw/gpef_ports.sv
// Port E and port F pin logic with AXI4-Lite register access.
// Assumes SPI, SCI and timers sit beside it and pads resolve out/oe.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module gpef_ports
  import gpef_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // AXI4-Lite write address
  input  wire logic [AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [AXI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [AXI_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Port E pins
  input  wire logic [PE_W-1:0]        portEIn,
  output logic      [PE_W-1:0]        portEOut,
  output logic      [PE_W-1:0]        portEOe,
  // Port F pins
  input  wire logic [PF_W-1:0]        portFIn,
  output logic      [PF_W-1:0]        portFOut,
  output logic      [PF_W-1:0]        portFOe,
  // Peripheral side
  input  wire gpef_periph_ctrl_t      periphCtrl,
  input  wire gpef_periph_drive_t     periphDrive,
  output gpef_periph_sense_t          periphSense
);

  // ****************************************************************
  // State
  // ****************************************************************
  gpef_state_t st;
  gpef_state_t next_st;

  logic [PE_W-1:0] eSync;
  logic [PF_W-1:0] fSync;

  // Pin ownership and peripheral drive
  logic            slaveSelOwned;
  logic [PE_W-1:0] eOwn;
  logic [PE_W-1:0] ePerOut;
  logic [PE_W-1:0] ePerOe;
  logic [PF_W-1:0] fOwn;
  logic [PF_W-1:0] fPerOut;
  logic [PF_W-1:0] fPerOe;

  // Read-back views of the data registers
  logic [PE_W-1:0] eView;
  logic [PF_W-1:0] fView;

  // Bus handshake terms
  logic awTake;
  logic wTake;
  logic arTake;
  logic awHave;
  logic wHave;
  logic [AXI_ADDR_W-1:0] wrAddr;
  logic [AXI_DATA_W-1:0] wrData;
  logic [3:0]            wrStrb;
  logic [IDX_W-1:0]      wrIdx;
  logic [IDX_W-1:0]      rdIdx;

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  gpef_sync #(
    .W    (PE_W)
  ) u_sync_e (
    .clk  (clk),
    .din  (portEIn),
    .dout (eSync)
  );

  gpef_sync #(
    .W    (PF_W)
  ) u_sync_f (
    .clk  (clk),
    .din  (portFIn),
    .dout (fSync)
  );

  // ****************************************************************
  // Port E pin sharing
  // ****************************************************************
  // Slave select is free when SPI is off, or master without fault check
  assign slaveSelOwned = periphCtrl.spiEnableBit &&
         !(periphCtrl.spiMasterSelect &&
           !periphCtrl.modeFaultEnable);

  // Which port E pins a peripheral currently holds
  always_comb begin
    eOwn          = '0;
    eOwn[PE_SCLK] = periphCtrl.spiEnableBit;
    eOwn[PE_MOSI] = periphCtrl.spiEnableBit;
    eOwn[PE_MISO] = periphCtrl.spiEnableBit;
    eOwn[PE_SS]   = slaveSelOwned;
    eOwn[PE_TA1]  = periphCtrl.timerAEdgeLevel[1] != ELS_OFF;
    eOwn[PE_TA0]  = periphCtrl.timerAEdgeLevel[0] != ELS_OFF;
    eOwn[PE_RXD]  = periphCtrl.sciEnableBit;
    eOwn[PE_TXD]  = periphCtrl.sciEnableBit;
  end

  // Direction the peripheral imposes on each port E pin
  always_comb begin
    ePerOe          = '0;
    ePerOe[PE_SCLK] = periphCtrl.spiMasterSelect;
    ePerOe[PE_MOSI] = periphCtrl.spiMasterSelect;
    ePerOe[PE_MISO] = !periphCtrl.spiMasterSelect;
    ePerOe[PE_SS]   = 1'b0;
    ePerOe[PE_TA1]  = periphDrive.timerAOe[1];
    ePerOe[PE_TA0]  = periphDrive.timerAOe[0];
    ePerOe[PE_RXD]  = 1'b0;
    ePerOe[PE_TXD]  = 1'b1;
  end

  // Level the peripheral drives on each port E pin
  always_comb begin
    ePerOut          = '0;
    ePerOut[PE_SCLK] = periphDrive.spiSclkOut;
    ePerOut[PE_MOSI] = periphDrive.spiMosiOut;
    ePerOut[PE_MISO] = periphDrive.spiMisoOut;
    ePerOut[PE_TA1]  = periphDrive.timerAOut[1];
    ePerOut[PE_TA0]  = periphDrive.timerAOut[0];
    ePerOut[PE_TXD]  = periphDrive.sciTxdOut;
  end

  // ****************************************************************
  // Port F pin sharing
  // ****************************************************************
  // Timer channels claim their pins when their select is not off
  always_comb begin
    fOwn    = '0;
    fPerOut = '0;
    fPerOe  = '0;
    for (int i = 0; i < TA_CH - 2; i++) begin
      fOwn[PF_TA2 + i] =
        periphCtrl.timerAEdgeLevel[i + 2] != ELS_OFF;
      fPerOut[PF_TA2 + i] = periphDrive.timerAOut[i + 2];
      fPerOe[PF_TA2 + i]  = periphDrive.timerAOe[i + 2];
    end
    for (int j = 0; j < TB_CH; j++) begin
      fOwn[PF_TB0 + j] =
        periphCtrl.timerBEdgeLevel[j] != ELS_OFF;
      fPerOut[PF_TB0 + j] = periphDrive.timerBOut[j];
      fPerOe[PF_TB0 + j]  = periphDrive.timerBOe[j];
    end
  end

  // ****************************************************************
  // Pad drive
  // ****************************************************************
  // Owner picks the level; free pins follow latch and direction
  assign portEOut = (eOwn & ePerOut) | (~eOwn & st.eLatch);
  assign portEOe  = (eOwn & ePerOe) | (~eOwn & st.eDir);
  assign portFOut = (fOwn & fPerOut) | (~fOwn & st.fLatch);
  assign portFOe  = (fOwn & fPerOe) | (~fOwn & st.fDir);

  // Synchronised pin levels go back to the peripherals
  always_comb begin
    periphSense.spiSclkIn     = eSync[PE_SCLK];
    periphSense.spiMosiIn     = eSync[PE_MOSI];
    periphSense.spiMisoIn     = eSync[PE_MISO];
    periphSense.spiSlaveSelIn = eSync[PE_SS];
    periphSense.sciRxdIn      = eSync[PE_RXD];
    periphSense.timerAIn      = {fSync[PF_TB0-1:PF_TA2],
                                 eSync[PE_TA1:PE_TA0]};
    periphSense.timerBIn      = fSync[PF_TB1:PF_TB0];
  end

  // ****************************************************************
  // Read-back views
  // ****************************************************************
  // Direction bit picks latch or pin even for peripheral-held pins
  assign eView = (st.eDir & st.eLatch) | (~st.eDir & eSync);
  assign fView = (st.fDir & st.fLatch) | (~st.fDir & fSync);

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Address and data are taken independently while no answer waits
  assign s_axi_awready = !st.awHeld && !st.bValid;
  assign s_axi_wready  = !st.wHeld && !st.bValid;
  assign s_axi_arready = !st.rValid;

  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake  = s_axi_wvalid && s_axi_wready;
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign awHave = st.awHeld || awTake;
  assign wHave  = st.wHeld || wTake;

  // Payload of the write in progress, held or arriving now
  assign wrAddr = st.awHeld ? st.awAddr : s_axi_awaddr;
  assign wrData = st.wHeld ? st.wData : s_axi_wdata;
  assign wrStrb = st.wHeld ? st.wStrb : s_axi_wstrb;
  assign wrIdx  = wrAddr[AXI_ADDR_W-1:2];
  assign rdIdx  = s_axi_araddr[AXI_ADDR_W-1:2];

  // Answer channels come straight from the state
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp  = st.bResp;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rdata  = st.rData;
  assign s_axi_rresp  = st.rResp;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus slave and register file in one step
  always_comb begin
    next_st = st;

    // Write response retires on bready
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    // Capture halves of a write that arrive apart
    if (awTake) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (wTake) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end

    // Both halves present: update the register and answer
    if (awHave && wHave && !st.bValid) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = RESP_OKAY;
      unique case (wrIdx)
        IDX_PORT_E_DATA: begin
          if (wrStrb[0]) begin
            next_st.eLatch = wrData[PE_W-1:0];
          end
        end
        IDX_PORT_F_DATA: begin
          if (wrStrb[0]) begin
            next_st.fLatch = wrData[PF_W-1:0];
          end
        end
        IDX_PORT_E_DIR: begin
          if (wrStrb[0]) begin
            next_st.eDir = wrData[PE_W-1:0];
          end
        end
        IDX_PORT_F_DIR: begin
          if (wrStrb[0]) begin
            next_st.fDir = wrData[PF_W-1:0];
          end
        end
        IDX_PORT_E_OWN, IDX_PORT_F_OWN: begin
          next_st.bResp = RESP_OKAY; // Read-only, write dropped
        end
        default: begin
          next_st.bResp = RESP_DECERR;
        end
      endcase
    end

    // Read data retires on rready
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // Read: sample the register on the address edge
    if (arTake) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = RESP_OKAY;
      next_st.rData  = '0;
      unique case (rdIdx)
        IDX_PORT_E_DATA: next_st.rData[PE_W-1:0] = eView;
        IDX_PORT_F_DATA: next_st.rData[PF_W-1:0] = fView;
        IDX_PORT_E_DIR:  next_st.rData[PE_W-1:0] = st.eDir;
        IDX_PORT_F_DIR:  next_st.rData[PF_W-1:0] = st.fDir;
        IDX_PORT_E_OWN:  next_st.rData[PE_W-1:0] = eOwn;
        IDX_PORT_F_OWN:  next_st.rData[PF_W-1:0] = fOwn;
        default:         next_st.rResp = RESP_DECERR;
      endcase
    end

    // Synchronous reset: control cleared, data latches kept
    if (!resetn) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b0;
      next_st.bResp  = RESP_OKAY;
      next_st.rValid = 1'b0;
      next_st.rResp  = RESP_OKAY;
      next_st.rData  = '0;
      next_st.eDir   = PE_DIR_RESET;
      next_st.fDir   = PF_DIR_RESET;
      next_st.eLatch = st.eLatch;
      next_st.fLatch = st.fLatch;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // One register for all block state
  always_ff @(posedge clk) begin
    st <= next_st;
  end

endmodule

`default_nettype wire

// file: hw/gpef_pkg.sv
// Constants, register map and carrier types for the port E/F block.
// Assumes a single 40 MHz clock and an AXI4-Lite master on the bus.
//
// How it works
// - Port E holds eight data latches, each pin steered by its direction bit.
// - Direction bit one enables the pin driver; zero leaves a Hi-Z input.
// - Reset clears all eight port E direction bits.
// - Port E data read gives latch where direction is one, else pin.
// - Latch writes with strobe bit 0 set always land; an input pin reads back unchanged.
// - Bit 7 is SPI clock, out as master, in as slave, else GPIO.
// - Bit 6 is SPI MOSI while SPI enabled, else GPIO.
// - Bit 5 is SPI MISO while SPI enabled, else GPIO.
// - Bit 4 is slave select unless SPI off or master without fault enable.
// - As SPI slave, the bit 4 direction bit has no effect on the pin.
// - Peripheral sets port E pin direction; direction bits still pick readback.
// - Bits 3 and 2 are timer A channels 1 and 0 when selected.
// - Bit 1 is SCI receive input while SCI enabled, else GPIO.
// - Bit 0 drives SCI transmit output while SCI enabled, else GPIO.
// - Port F holds seven data latches that reset leaves unchanged.
// - Port F direction bits enable drivers; reset clears them all.
// - Port F data read gives latch for outputs, pin for inputs.
// - Port F bits 3 to 0 are timer A channels 5 to 2 when selected.
// - Port F bits 5 and 4 are timer B channels 1 and 0 when selected.
// - Timer sets port F pin direction; direction bits still pick readback.
// - Port E has eight pins: two timer, two SCI, four SPI.

package gpef_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int PE_W       = 8;
  localparam int PF_W       = 7;
  localparam int REG_W      = 8;
  localparam int IDX_W      = 6;
  localparam int TA_CH      = 6;
  localparam int TB_CH      = 2;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 6'h08;
  localparam logic [IDX_W-1:0] IDX_PORT_F_DATA = 6'h09;
  localparam logic [IDX_W-1:0] IDX_PORT_E_DIR  = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_PORT_F_DIR  = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_PORT_E_OWN  = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_PORT_F_OWN  = 6'h0f;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PE_W-1:0] PE_DIR_RESET = 8'h00;
  localparam logic [PF_W-1:0] PF_DIR_RESET = 7'h00;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************************************
  // Pin positions
  // ****************************************************************
  localparam int PE_SCLK = 7;
  localparam int PE_MOSI = 6;
  localparam int PE_MISO = 5;
  localparam int PE_SS   = 4;
  localparam int PE_TA1  = 3;
  localparam int PE_TA0  = 2;
  localparam int PE_RXD  = 1;
  localparam int PE_TXD  = 0;
  localparam int PF_TA2  = 0;
  localparam int PF_TB0  = 4;
  localparam int PF_TB1  = 5;

  // Edge/level select code that leaves a channel off its pin
  localparam logic [1:0] ELS_OFF = 2'h0;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic                   spiEnableBit;
    logic                   spiMasterSelect;
    logic                   modeFaultEnable;
    logic                   sciEnableBit;
    logic [TA_CH-1:0][1:0]  timerAEdgeLevel;
    logic [TB_CH-1:0][1:0]  timerBEdgeLevel;
  } gpef_periph_ctrl_t;

  typedef struct packed {
    logic              spiSclkOut;
    logic              spiMosiOut;
    logic              spiMisoOut;
    logic              sciTxdOut;
    logic [TA_CH-1:0]  timerAOut;
    logic [TA_CH-1:0]  timerAOe;
    logic [TB_CH-1:0]  timerBOut;
    logic [TB_CH-1:0]  timerBOe;
  } gpef_periph_drive_t;

  typedef struct packed {
    logic              spiSclkIn;
    logic              spiMosiIn;
    logic              spiMisoIn;
    logic              spiSlaveSelIn;
    logic              sciRxdIn;
    logic [TA_CH-1:0]  timerAIn;
    logic [TB_CH-1:0]  timerBIn;
  } gpef_periph_sense_t;

  typedef struct packed {
    logic                   awHeld;
    logic [AXI_ADDR_W-1:0]  awAddr;
    logic                   wHeld;
    logic [AXI_DATA_W-1:0]  wData;
    logic [3:0]             wStrb;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   rValid;
    logic [AXI_DATA_W-1:0]  rData;
    logic [1:0]             rResp;
    logic [PE_W-1:0]        eLatch;
    logic [PE_W-1:0]        eDir;
    logic [PF_W-1:0]        fLatch;
    logic [PF_W-1:0]        fDir;
  } gpef_state_t;

endpackage

// file: hw/gpef_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clk; output is stable two edges on.
`timescale 1ns/10ps
`default_nettype none

module gpef_sync #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clk,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpef_sync_state_t;

  gpef_sync_state_t st;
  gpef_sync_state_t next_st;

  // Shift levels through two stages; only stage2 leaves the module
  always_comb begin
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
  end

  // Register stages
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign dout = st.stage2;

endmodule

`default_nettype wire

// file: bench/gpef_ports_sva.sv
// Checker for the port E/F block: bus answers and pin steering.
// Assumes it is bound to gpef_ports and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module gpef_ports_sva
  import gpef_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Bus handshakes
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  // Pins and peripherals
  input wire logic [PE_W-1:0]       portEIn,
  input wire logic [PE_W-1:0]       portEOut,
  input wire logic [PE_W-1:0]       portEOe,
  input wire logic [PF_W-1:0]       portFOut,
  input wire logic [PF_W-1:0]       portFOe,
  input wire gpef_periph_ctrl_t     periphCtrl,
  input wire gpef_periph_drive_t    periphDrive,
  input wire gpef_periph_sense_t    periphSense
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ******************************************************************
  // Bus handshake steps
  // ******************************************************************
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w;
    s_axi_wvalid && s_axi_wready;
  endsequence

  write_answer_a: assert property ((s_aw and s_w) |=> s_axi_bvalid)
    else $error("write gave no response");
  write_holds_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  read_holds_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");

  // ******************************************************************
  // Pin steering
  // ******************************************************************
  reset_clear_a: assert property (
    !$past(resetn) && periphCtrl == '0 |-> portEOe == '0 && portFOe == '0)
    else $error("drivers on after reset");
  sci_pins_a: assert property (periphCtrl.sciEnableBit |->
    portEOe[PE_TXD] && !portEOe[PE_RXD]
    && portEOut[PE_TXD] == periphDrive.sciTxdOut) else $error("sci pins");
  rx_sense_a: assert property ($past(resetn, 2) |->
    periphSense.sciRxdIn == $past(portEIn[PE_RXD], 2))
    else $error("receive pin not passed on");
  spi_master_a: assert property (periphCtrl.spiEnableBit
    && periphCtrl.spiMasterSelect |-> portEOe[7:5] == 3'h6
    && portEOut[PE_SCLK] == periphDrive.spiSclkOut
    && portEOut[PE_MOSI] == periphDrive.spiMosiOut) else $error("spi master");
  spi_slave_a: assert property (periphCtrl.spiEnableBit
    && !periphCtrl.spiMasterSelect |-> portEOe[7:4] == 4'h2
    && portEOut[PE_MISO] == periphDrive.spiMisoOut) else $error("spi slave");
  slave_sel_a: assert property (periphCtrl.spiEnableBit &&
    !(periphCtrl.spiMasterSelect && !periphCtrl.modeFaultEnable)
    |-> !portEOe[PE_SS]) else $error("slave select driven");
  timer_e_a: assert property (periphCtrl.timerAEdgeLevel[1] != ELS_OFF
    |-> portEOe[PE_TA1] == periphDrive.timerAOe[1]
    && portEOut[PE_TA1] == periphDrive.timerAOut[1]) else $error("timer e");
  timer_f_a: assert property (periphCtrl.timerAEdgeLevel[5] != ELS_OFF
    |-> portFOe[3] == periphDrive.timerAOe[5]) else $error("timer f");
  timer_b_a: assert property (periphCtrl.timerBEdgeLevel[0] != ELS_OFF
    |-> portFOe[PF_TB0] == periphDrive.timerBOe[0]
    && portFOut[PF_TB0] == periphDrive.timerBOut[0]) else $error("timer b");
endmodule

bind gpef_ports gpef_ports_sva sva_u (.*);

`default_nettype wire

// file: bench/gpef_board.sv
// Board model: each pad shows the block's level while it drives,
// else the level the board puts there. Assumes the bench sets those.
`timescale 1ns/10ps
`default_nettype none

module gpef_board
  import gpef_pkg::*;
(
  // Block side
  input  wire logic [PE_W-1:0] portEOut,
  input  wire logic [PE_W-1:0] portEOe,
  input  wire logic [PF_W-1:0] portFOut,
  input  wire logic [PF_W-1:0] portFOe,
  // Board levels
  input  wire logic [PE_W-1:0] extE,
  input  wire logic [PF_W-1:0] extF,
  // Pad levels seen by the block
  output logic      [PE_W-1:0] portEIn,
  output logic      [PF_W-1:0] portFIn
);
  // Driven pads win over the board
  assign portEIn = (portEOe & portEOut) | (~portEOe & extE);
  assign portFIn = (portFOe & portFOut) | (~portFOe & extF);
endmodule

`default_nettype wire

// file: bench/gpef_ports_tb_top.sv
// Bench for the port E/F block: bus tasks, one task per scenario.
// Assumes the board model drives the pads and the checker is bound.
`timescale 1ns/10ps
`default_nettype none

module gpef_ports_tb_top
  import gpef_pkg::*;
;
  localparam logic [7:0] A_E  = {IDX_PORT_E_DATA, 2'h0};
  localparam logic [7:0] A_F  = {IDX_PORT_F_DATA, 2'h0};
  localparam logic [7:0] A_ED = {IDX_PORT_E_DIR, 2'h0};
  localparam logic [7:0] A_FD = {IDX_PORT_F_DIR, 2'h0};
  logic                  clk, resetn, s_axi_awvalid, s_axi_awready;
  logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
  logic [PE_W-1:0]       portEIn, portEOut, portEOe, extE;
  logic [PF_W-1:0]       portFIn, portFOut, portFOe, extF;
  gpef_periph_ctrl_t     periphCtrl;
  gpef_periph_drive_t    periphDrive;
  gpef_periph_sense_t    periphSense;
  int                    nFail = 0, nChecks = 0, cycles = 0;

  gpef_ports dut_u (.*);
  gpef_board board_u (.*);

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Handshakes sampled at the rising edge; each channel drops when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      rsp = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    rd(A_ED);
    chk(rdv, 32'h0);
    rd(A_FD);
    chk(rdv, 32'h0);
    chk(portEOe, 8'h00);
  endtask

  // Latch loaded first so the pin never shows a stale level
  task automatic t_port_e();
    extE <= 8'h5a;
    wr(A_E, 32'ha5);
    chk(rsp, RESP_OKAY);
    cyc(3);
    rd(A_E);
    chk(rdv, 32'h5a);
    wr(A_ED, 32'h0f);
    chk(portEOut, 8'ha5);
    chk(portEOe, 8'h0f);
    cyc(3);
    rd(A_E);
    chk(rdv, 32'h55);
  endtask

  // Includes a reset in mid-run that must keep the latches
  task automatic t_port_f();
    extF <= 7'h2a;
    wr(A_F, 32'hff);
    wr(A_FD, 32'hff);
    rd(A_FD);
    chk(rdv, 32'h7f);
    rd(A_F);
    chk(rdv, 32'h7f);
    resetn <= 1'h0;
    cyc(2);
    resetn <= 1'h1;
    rd(A_ED);
    chk(rdv, 32'h0);
    chk(portFOe, 7'h00);
    rd(A_F);
    chk(rdv, 32'h2a);
    wr(A_FD, 32'h7f);
    rd(A_F);
    chk(rdv, 32'h7f);
  endtask

  task automatic t_spi();
    wr(A_E, 32'h3c);
    wr(A_ED, 32'hff);
    periphCtrl.spiEnableBit <= 1'h1;
    periphDrive.spiMisoOut <= 1'h1;
    extE <= 8'hc0;
    cyc(3);
    chk(portEOe[7:4], 4'h2);
    chk({periphSense.spiSclkIn, periphSense.spiMosiIn}, 2'h3);
    rd(A_E);
    chk(rdv, 32'h3c);
    periphCtrl.spiMasterSelect <= 1'h1;
    periphDrive.spiSclkOut <= 1'h1;
    cyc(1);
    chk(portEOe[7:4], 4'hd);
    chk(portEOut[7:6], 2'h2);
    periphCtrl.spiEnableBit <= 1'h0;
    cyc(1);
    chk(portEOut[7:4], 4'h3);
  endtask

  task automatic t_sci_tmr();
    wr(A_ED, 32'h0);
    wr(A_FD, 32'h0);
    periphCtrl.sciEnableBit <= 1'h1;
    periphCtrl.timerAEdgeLevel <= {TA_CH{2'h1}};
    periphCtrl.timerBEdgeLevel <= {TB_CH{2'h1}};
    periphDrive.sciTxdOut <= 1'h1;
    periphDrive.timerAOe <= 6'h3f;
    periphDrive.timerAOut <= 6'h15;
    periphDrive.timerBOe <= 2'h3;
    periphDrive.timerBOut <= 2'h2;
    cyc(3);
    chk(portEOe[3:0], 4'hd);
    chk({portEOut[3:2], portEOut[0]}, 3'h3);
    chk(portFOe[5:0], 6'h3f);
    rd(A_F);
    chk(rdv, 32'h25);
    rd(8'h38);
    chk(rdv, 32'hf);
    // Every edge/level code, ending with the one that frees the pin
    for (int c = 3; c >= 0; c--) begin
      periphCtrl.timerBEdgeLevel[0] <= 2'(c);
      cyc(2);
      chk(portFOe[PF_TB0], c != 0);
    end
  endtask

  task automatic t_bus();
    rd(8'h00);
    chk(rsp, RESP_DECERR);
    chk(rdv, 32'h0);
    wr(8'h04, 32'h1);
    chk(rsp, RESP_DECERR);
  endtask

  // ******************************************************************
  // Main sequence and hang guard
  // ******************************************************************
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {periphCtrl, periphDrive, extE, extF, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    cyc(2);
    resetn <= 1'h1;
    t_reset();
    t_port_e();
    t_port_f();
    t_spi();
    t_sci_tmr();
    t_bus();
    conclude();
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nFail++;
      conclude();
    end
  end
endmodule

`default_nettype wire
